// *** design/lbs_pkg.sv ***
package lbs_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h00;
  localparam logic [7:0] OFS_CONTROLLER_FLAGS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_CONTROL = 8'h10;

  // ------------------------------------------------------------
  // baud divisor fields
  // ------------------------------------------------------------
  localparam int BD_INT_LSB = 0;
  localparam int BD_INT_W = 16;
  localparam int BD_FRAC_LSB = 16;
  localparam int BD_FRAC_W = 4;
  localparam logic [15:0] BD_INT_RST = 16'h0001;
  localparam logic [3:0] BD_FRAC_RST = 4'h0;
  localparam int TICKS_PER_BIT = 16;

  // ------------------------------------------------------------
  // controller flag bits
  // ------------------------------------------------------------
  localparam int FL_TX_LEVEL = 9;
  localparam int FL_RX_LEVEL = 8;
  localparam int FL_IDLE = 6;
  localparam int FL_ERROR = 5;
  localparam int FL_RESP_TX = 4;
  localparam int FL_RESP_RX = 3;
  localparam int FL_HEADER = 2;
  localparam int FL_BUF_FREE = 1;
  localparam int FL_MSG_RX = 0;
  localparam logic LEVEL_RST = 1'b1;

  // ------------------------------------------------------------
  // interrupt and control bits
  // ------------------------------------------------------------
  localparam int IRQ_W = 3;
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_RX_DONE = 1;
  localparam int IRQ_ERROR = 2;
  localparam int CTRL_RESET_MODE = 0;
  localparam logic CTRL_RESET_MODE_RST = 1'b1;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LBS_PH_IDLE = 2'b00,
    LBS_PH_HEADER = 2'b01,
    LBS_PH_RESP_TX = 2'b10,
    LBS_PH_RESP_RX = 2'b11
  } lbs_phase_e;

  typedef struct packed {
    logic tx_initiate;
    logic header_start;
    logic resp_tx_start;
    logic resp_rx_start;
    logic tx_msg_complete;
    logic rx_msg_complete;
    logic error_detect;
    logic buf_write;
  } lbs_frame_ev_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lbs_bus_req_s;

endpackage

// *** design/lbs_baud_gen.sv ***
`timescale 1ns/1ps
module lbs_baud_gen #(
  parameter int INT_W = 16,
  parameter int FRAC_W = 4,
  parameter int TICKS = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // divisor and run control
  input wire logic run_i,
  input wire logic [INT_W-1:0] int_div_i,
  input wire logic [FRAC_W-1:0] frac_i,
  // ticks
  output logic sample_tick_o,
  output logic bit_tick_o
);

  logic [INT_W-1:0] cnt;
  logic [FRAC_W-1:0] acc;
  logic stretch;
  logic [$clog2(TICKS)-1:0] sub;
  logic [INT_W-1:0] limit;
  logic [FRAC_W:0] acc_sum;
  logic period_end;

  // a zero divisor would stall the tick, so it is treated as one
  assign limit = (int_div_i == '0) ? INT_W'(1) : int_div_i;
  assign acc_sum = {1'b0, acc} + {1'b0, frac_i};
  assign period_end = (cnt >= limit - INT_W'(1)) && !stretch;

  // integer count, held one clock longer after a fraction carry
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !run_i) begin
      cnt <= '0;
      stretch <= 1'b0;
      acc <= '0;
    end else if (stretch) begin
      stretch <= 1'b0;
      cnt <= '0;
    end else if (period_end) begin
      cnt <= '0;
      acc <= acc_sum[FRAC_W-1:0];
      stretch <= acc_sum[FRAC_W];
    end else begin
      cnt <= cnt + INT_W'(1);
    end
  end

  // tick at sixteen times the bit rate, bit tick every sixteenth
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !run_i) begin
      sample_tick_o <= 1'b0;
      bit_tick_o <= 1'b0;
      sub <= '0;
    end else begin
      sample_tick_o <= period_end && !acc_sum[FRAC_W]
                       || stretch;
      bit_tick_o <= 1'b0;
      if (period_end && !acc_sum[FRAC_W] || stretch) begin
        sub <= sub + 1'b1;
        bit_tick_o <= (sub == $bits(sub)'(TICKS - 1));
      end
    end
  end

endmodule

// *** design/lbs_lin_baud_status.sv ***
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - the baud generator ticks sixteen times per bit, so one bit spans sixteen ticks.
// - the divisor register holds a 16-bit integer divisor and a 4-bit fraction.
// - the clock is divided by integer plus fraction over sixteen for each tick.
// - the divisor register accepts writes only while the controller is in reset mode.
// - the fraction sits in bits 19 to 16, is read-write and resets to zero.
// - the integer divisor sits in bits 15 to 0, is read-write and resets to one.
// - divisor bits 31 to 20 read as zero and software leaves them alone.
// - the controller flag register is read-only and writes never change it.
// - flag bit 9 shows the transmit line level, one when dominant, reset one.
// - flag bit 8 shows the receive line level, one when dominant, reset one.
// - the response-transmitting flag clears on transmit message complete.
// - the response-receiving flag clears on receive message complete.
// - flag bits 31 to 10 and bit 7 read as zero.
// - header, response-transmit and response-receive flags are set during those phases.
// - the error flag sets on bit error or clamped line and clears when a new transmission starts.
module lbs_lin_baud_status (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire lbs_pkg::lbs_bus_req_s bus_i,
  output logic [31:0] rdata_o,
  // frame sequencer events and levels
  input wire lbs_pkg::lbs_frame_ev_s ev_i,
  input wire logic buf_released_i,
  input wire logic txd_pin_i,
  input wire logic rxd_pin_i,
  // outputs
  output logic reset_mode_o,
  output logic sample_tick_o,
  output logic bit_tick_o,
  output logic irq_o
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // interrupt words sit in the low bits and the rest reads zero
  function automatic logic [31:0] irq_word(input logic [lbs_pkg::IRQ_W-1:0] v);
    irq_word = '0;
    irq_word[lbs_pkg::IRQ_W-1:0] = v;
  endfunction

  // one write strobe per writable register, decoded once
  logic wr_div;
  logic wr_irq_st;
  logic wr_irq_mask;
  logic wr_ctrl;

  // the flag register has no write decode at all
  assign wr_div = bus_i.wr && hit(bus_i.addr, lbs_pkg::OFS_BAUD_DIVISOR);
  assign wr_irq_st = bus_i.wr && hit(bus_i.addr, lbs_pkg::OFS_IRQ_STATUS);
  assign wr_irq_mask = bus_i.wr && hit(bus_i.addr, lbs_pkg::OFS_IRQ_MASK);
  assign wr_ctrl = bus_i.wr && hit(bus_i.addr, lbs_pkg::OFS_CONTROL);

  // ------------------------------------------------------------
  // control and divisor registers
  // ------------------------------------------------------------
  logic [lbs_pkg::BD_INT_W-1:0] int_div;
  logic [lbs_pkg::BD_FRAC_W-1:0] frac_div;
  logic run;

  // reset mode holds the generator still while software sets it up
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      reset_mode_o <= lbs_pkg::CTRL_RESET_MODE_RST;
    end else if (wr_ctrl) begin
      reset_mode_o <= bus_i.wdata[lbs_pkg::CTRL_RESET_MODE];
    end
  end

  // the generator runs only outside reset mode and restarts on every exit
  assign run = !reset_mode_o;

  // divisor writes only land in reset mode
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      int_div <= lbs_pkg::BD_INT_RST;
      frac_div <= lbs_pkg::BD_FRAC_RST;
    end else if (wr_div && reset_mode_o) begin
      int_div <= bus_i.wdata[lbs_pkg::BD_INT_LSB +: lbs_pkg::BD_INT_W];
      frac_div <= bus_i.wdata[lbs_pkg::BD_FRAC_LSB +: lbs_pkg::BD_FRAC_W];
    end
  end

  // ------------------------------------------------------------
  // baud generator
  // ------------------------------------------------------------
  lbs_baud_gen #(
    .INT_W(lbs_pkg::BD_INT_W),
    .FRAC_W(lbs_pkg::BD_FRAC_W),
    .TICKS(lbs_pkg::TICKS_PER_BIT)
  // divisor fields feed the generator directly; they cannot move while it runs
  ) u_baud (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .run_i(run),
    .int_div_i(int_div),
    .frac_i(frac_div),
    .sample_tick_o(sample_tick_o),
    .bit_tick_o(bit_tick_o)
  );

  // ------------------------------------------------------------
  // line levels
  // ------------------------------------------------------------
  logic tx_level;
  logic rx_level;

  // lin is dominant low, so the flag is the inverted pin
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tx_level <= lbs_pkg::LEVEL_RST;
      rx_level <= lbs_pkg::LEVEL_RST;
    end else begin
      tx_level <= !txd_pin_i;
      rx_level <= !rxd_pin_i;
    end
  end

  // ------------------------------------------------------------
  // frame phase
  // ------------------------------------------------------------
  lbs_pkg::lbs_phase_e phase;
  lbs_pkg::lbs_phase_e next_phase;

  // one phase at a time; completion events close the response
  always_comb begin
    next_phase = phase;
    case (phase)
      lbs_pkg::LBS_PH_IDLE: begin
        if (ev_i.header_start) begin
          next_phase = lbs_pkg::LBS_PH_HEADER;
        end
      end
      lbs_pkg::LBS_PH_HEADER: begin
        if (ev_i.resp_tx_start) begin
          next_phase = lbs_pkg::LBS_PH_RESP_TX;
        end else if (ev_i.resp_rx_start) begin
          next_phase = lbs_pkg::LBS_PH_RESP_RX;
        end
      end
      lbs_pkg::LBS_PH_RESP_TX: begin
        if (ev_i.tx_msg_complete) begin
          next_phase = lbs_pkg::LBS_PH_IDLE;
        end
      end
      lbs_pkg::LBS_PH_RESP_RX: begin
        if (ev_i.rx_msg_complete) begin
          next_phase = lbs_pkg::LBS_PH_IDLE;
        end
      end
      default: begin
        next_phase = lbs_pkg::LBS_PH_IDLE;
      end
    endcase
  end

  // phase register, idle after reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      phase <= lbs_pkg::LBS_PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // ------------------------------------------------------------
  // error and message-received flags
  // ------------------------------------------------------------
  logic err_flag;
  logic msg_rx_flag;

  // a detection in the same cycle as a new start wins over the clear
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      err_flag <= 1'b0;
    end else if (ev_i.error_detect) begin
      err_flag <= 1'b1;
    end else if (ev_i.tx_initiate) begin
      err_flag <= 1'b0;
    end
  end

  // valid message until the buffer is written or a new request starts
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      msg_rx_flag <= 1'b0;
    end else if (ev_i.rx_msg_complete) begin
      msg_rx_flag <= 1'b1;
    end else if (ev_i.tx_initiate || ev_i.buf_write) begin
      msg_rx_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  logic [lbs_pkg::IRQ_W-1:0] irq_status;
  logic [lbs_pkg::IRQ_W-1:0] irq_mask;
  logic [lbs_pkg::IRQ_W-1:0] irq_set;
  logic [lbs_pkg::IRQ_W-1:0] irq_clr;

  // completion and error events raise the sticky bits
  assign irq_set[lbs_pkg::IRQ_TX_DONE] = ev_i.tx_msg_complete;
  assign irq_set[lbs_pkg::IRQ_RX_DONE] = ev_i.rx_msg_complete;
  assign irq_set[lbs_pkg::IRQ_ERROR] = ev_i.error_detect;
  assign irq_clr = wr_irq_st ? bus_i.wdata[lbs_pkg::IRQ_W-1:0] : '0;

  // sticky bits, write one to clear; a fresh event beats the clear
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  // mask of the same layout, all masked after reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_mask <= '0;
    end else if (wr_irq_mask) begin
      irq_mask <= bus_i.wdata[lbs_pkg::IRQ_W-1:0];
    end
  end

  // registered, so the line lags the status bit by one clock
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // ------------------------------------------------------------
  // read-back
  // ------------------------------------------------------------
  logic [31:0] flags_word;
  logic [31:0] div_word;
  logic [31:0] next_rdata;

  // unlisted bits stay zero in both words
  always_comb begin
    flags_word = '0;
    flags_word[lbs_pkg::FL_TX_LEVEL] = tx_level;
    flags_word[lbs_pkg::FL_RX_LEVEL] = rx_level;
    flags_word[lbs_pkg::FL_IDLE] = (phase == lbs_pkg::LBS_PH_IDLE);
    flags_word[lbs_pkg::FL_ERROR] = err_flag;
    flags_word[lbs_pkg::FL_RESP_TX] = (phase == lbs_pkg::LBS_PH_RESP_TX);
    flags_word[lbs_pkg::FL_RESP_RX] = (phase == lbs_pkg::LBS_PH_RESP_RX);
    flags_word[lbs_pkg::FL_HEADER] = (phase == lbs_pkg::LBS_PH_HEADER);
    flags_word[lbs_pkg::FL_BUF_FREE] = buf_released_i;
    flags_word[lbs_pkg::FL_MSG_RX] = msg_rx_flag;
    div_word = '0;
    div_word[lbs_pkg::BD_INT_LSB +: lbs_pkg::BD_INT_W] = int_div;
    div_word[lbs_pkg::BD_FRAC_LSB +: lbs_pkg::BD_FRAC_W] = frac_div;
  end

  // unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        lbs_pkg::OFS_BAUD_DIVISOR: begin
          next_rdata = div_word;
        end
        lbs_pkg::OFS_CONTROLLER_FLAGS: begin
          next_rdata = flags_word;
        end
        lbs_pkg::OFS_IRQ_STATUS: begin
          next_rdata = irq_word(irq_status);
        end
        lbs_pkg::OFS_IRQ_MASK: begin
          next_rdata = irq_word(irq_mask);
        end
        lbs_pkg::OFS_CONTROL: begin
          next_rdata = {31'h00000000, reset_mode_o};
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule

// *** tb/lbs_lin_baud_status_properties.sv ***
`timescale 1ns/1ps
module lbs_lin_baud_status_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire lbs_pkg::lbs_bus_req_s bus_i,
  input wire logic [31:0] rdata_o,
  // events and pins
  input wire lbs_pkg::lbs_frame_ev_s ev_i,
  input wire logic buf_released_i,
  input wire logic txd_pin_i,
  input wire logic rxd_pin_i,
  // outputs
  input wire logic reset_mode_o,
  input wire logic sample_tick_o,
  input wire logic bit_tick_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic rd_div;
  logic rd_flg;
  logic [3:0] n_tick;
  // read decodes of the two documented words
  assign rd_div = bus_i.rd && bus_i.addr == lbs_pkg::OFS_BAUD_DIVISOR;
  assign rd_flg = bus_i.rd && bus_i.addr == lbs_pkg::OFS_CONTROLLER_FLAGS;
  // sample ticks modulo sixteen, restarted while the generator is stopped
  always_ff @(posedge clk_i) begin
    if (!resetn_i || reset_mode_o) begin
      n_tick <= 4'h0;
    end else if (sample_tick_o) begin
      n_tick <= n_tick + 4'h1;
    end
  end
  AST_RDATA_IDLE: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_DIV_RSVD: assert property ($past(rd_div) |-> rdata_o[31:20] == 12'h000)
    else $error("divisor upper bits not zero");
  AST_FLAG_RSVD: assert property ($past(rd_flg) |-> rdata_o[31:10] == 22'h0 && !rdata_o[7])
    else $error("flag reserved bits not zero");
  // pins held steady long enough for the level register to follow
  AST_TX_LEVEL: assert property ($past(rd_flg) && $past(resetn_i, 2) && $stable(txd_pin_i)
    && $past(txd_pin_i, 2) == txd_pin_i && $past(txd_pin_i, 3) == txd_pin_i
    |-> rdata_o[9] == !txd_pin_i) else $error("transmit level bit wrong");
  AST_RX_LEVEL: assert property ($past(rd_flg) && $past(resetn_i, 2) && $stable(rxd_pin_i)
    && $past(rxd_pin_i, 2) == rxd_pin_i && $past(rxd_pin_i, 3) == rxd_pin_i
    |-> rdata_o[8] == !rxd_pin_i) else $error("receive level bit wrong");
  AST_STOPPED: assert property (reset_mode_o && $past(reset_mode_o)
    |-> !sample_tick_o && !bit_tick_o) else $error("ticks while in reset mode");
  AST_BIT_IN_SAMPLE: assert property (bit_tick_o |-> sample_tick_o)
    else $error("bit tick without sample tick");
  AST_BIT_EVERY_16: assert property (!reset_mode_o && sample_tick_o
    |-> bit_tick_o == (n_tick == 4'hF)) else $error("bit tick not on sixteenth sample");
endmodule

bind lbs_lin_baud_status lbs_lin_baud_status_properties props_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o), .ev_i(ev_i),
  .buf_released_i(buf_released_i), .txd_pin_i(txd_pin_i), .rxd_pin_i(rxd_pin_i),
  .reset_mode_o(reset_mode_o), .sample_tick_o(sample_tick_o), .bit_tick_o(bit_tick_o),
  .irq_o(irq_o));

// *** tb/lbs_lin_slave.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// slave nodes seen through the transceiver
// ------------------------------------------------------------
module lbs_lin_slave (
  // master transmit level and slave drive
  input wire logic txd_i,
  input wire logic dominate_i,
  // level returned to the master
  output logic rxd_o
);
  // wired-and bus with pull-up: a released bus is recessive, never stale
  assign rxd_o = txd_i & ~dominate_i;
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [7:0] A_DIV = lbs_pkg::OFS_BAUD_DIVISOR;
  localparam logic [7:0] A_FLG = lbs_pkg::OFS_CONTROLLER_FLAGS;
  localparam logic [7:0] A_STS = lbs_pkg::OFS_IRQ_STATUS;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  lbs_pkg::lbs_bus_req_s bus_i = '0;
  lbs_pkg::lbs_frame_ev_s ev_i = '0;
  logic buf_released_i = 1'b1;
  logic txd_pin_i = 1'b0;
  logic dominate = 1'b1;
  logic rxd_pin_i, reset_mode_o, sample_tick_o, bit_tick_o, irq_o;
  logic [31:0] rdata_o, q;
  logic [15:0] iv;
  logic [3:0] fv;
  int fails = 0;
  int n_compared = 0;
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  lbs_lin_baud_status dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .ev_i(ev_i), .buf_released_i(buf_released_i), .txd_pin_i(txd_pin_i),
    .rxd_pin_i(rxd_pin_i), .reset_mode_o(reset_mode_o), .sample_tick_o(sample_tick_o),
    .bit_tick_o(bit_tick_o), .irq_o(irq_o));
  lbs_lin_slave slave_u (.txd_i(txd_pin_i), .dominate_i(dominate), .rxd_o(rxd_pin_i));
  // ------------------------------------------------------------
  // tasks and expectations
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.wdata <= d;
    bus_i.wr <= 1'b1;
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
  endtask
  // data sampled a step after the edge, where it stands alone
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.rd <= 1'b1;
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    #1 d = rdata_o;
  endtask
  // dominant is a low pin, the flag reads one
  function automatic logic [31:0] flags_exp(input logic tx, input logic dom, input logic [6:0] st);
    return {22'h0, ~tx, ~(tx & ~dom), 1'b0, st};
  endfunction
  task automatic fl(input string what, input logic [6:0] st);
    rd(A_FLG, q);
    check(what, q, flags_exp(txd_pin_i, dominate, st));
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i);
    ev_i <= lbs_pkg::lbs_frame_ev_s'(8'h01 << i);
    @(posedge clk_i);
    ev_i <= '0;
  endtask
  // sixteen periods hold exactly frac carries of the accumulator
  task automatic measure(input logic [15:0] i_v, input logic [3:0] f_v);
    int n, k, nb;
    wr(lbs_pkg::OFS_CONTROL, 32'h1);
    wr(A_DIV, {12'h000, f_v, i_v});
    wr(lbs_pkg::OFS_CONTROL, 32'h0);
    #1 check("run mode", {31'h0, reset_mode_o}, 32'h0);
    wr(A_DIV, 32'h0000_0007);
    rd(A_DIV, q);
    check("divisor locked", q, {12'h000, f_v, i_v});
    n = 0;
    k = 0;
    nb = 0;
    while (k < 17 && n < 4000) begin
      @(posedge clk_i);
      #1;
      if (k > 0) n++;
      if (sample_tick_o === 1'b1) begin
        k++;
        if (k > 1 && bit_tick_o === 1'b1) nb++;
      end
    end
    check("tick span", 32'(n), 32'(16 * i_v + f_v));
    check("bit ticks", 32'(nb), 32'(32'd16 / lbs_pkg::TICKS_PER_BIT));
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #100000;
    fails++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h35EEE21A));
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1 check("reset mode after reset", {31'h0, reset_mode_o}, 32'h1);
    fl("flags after reset", 7'h42);
    rd(A_DIV, q);
    check("divisor after reset", q, 32'h0000_0001);
    $display("test reset done");
    // all four level pairs first, then random ones
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      {txd_pin_i, dominate} <= 2'(i < 4 ? i : $urandom);
      repeat (2) @(posedge clk_i);
      fl("line levels", 7'h42);
    end
    $display("test levels done");
    for (int i = 0; i < 5; i++) begin
      iv = i == 0 ? 16'hFFFF : 16'($urandom);
      fv = i == 0 ? 4'hF : 4'($urandom);
      wr(A_DIV, {12'h000, fv, iv});
      rd(A_DIV, q);
      check("divisor", q, {12'h000, fv, iv});
    end
    wr(A_FLG, $urandom);
    fl("flags after write", 7'h42);
    rd(8'hFC, q);
    check("unmapped", q, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      measure(i == 0 ? 16'h1 : 16'($urandom_range(2, 9)), i == 0 ? 4'h0 : 4'($urandom));
    end
    $display("test generator done");
    wr(lbs_pkg::OFS_IRQ_MASK, 32'h1);
    pulse(5);
    fl("resp tx outside frame", 7'h42);
    pulse(6);
    fl("header", 7'h06);
    pulse(5);
    fl("resp tx", 7'h12);
    pulse(3);
    fl("tx done", 7'h42);
    rd(A_STS, q);
    check("tx status", q, 32'h1);
    check("irq set", {31'h0, irq_o}, 32'h1);
    wr(A_STS, 32'h1);
    repeat (2) @(posedge clk_i);
    #1 check("irq cleared", {31'h0, irq_o}, 32'h0);
    pulse(6);
    pulse(4);
    fl("resp rx", 7'h0A);
    pulse(2);
    fl("rx done", 7'h43);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    rd(A_STS, q);
    check("rx status", q, 32'h2);
    pulse(1);
    fl("error", 7'h63);
    rd(A_STS, q);
    check("error status", q, 32'h6);
    pulse(7);
    fl("new transmission", 7'h42);
    $display("test events done");
    // second reset in mid-run: divisor, mode and flags return to reset values
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1 check("reset mode after second reset", {31'h0, reset_mode_o}, 32'h1);
    fl("flags after second reset", 7'h42);
    rd(A_DIV, q);
    check("divisor after second reset", q, 32'h0000_0001);
    rd(lbs_pkg::OFS_CONTROL, q);
    check("control after second reset", q, 32'h1);
    $display("test second reset done");
    finish_test();
  end
endmodule
